// *** code_space_bank_mapper_tb.sv ***
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module code_space_bank_mapper_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // clock, reset and bus master signals
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        hsel    = 1'b0;
  logic [11:0] haddr   = 12'h000;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  // design outputs and requestor wires
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, cpu_req, cpu_gnt, dma_req, dma_gnt;
  wire  [15:0] cpu_addr, dma_addr;
  wire         mem_valid, mem_to_ram, mem_src, cache_bypass, cache_invalidate;
  wire  [16:0] mem_addr;
  wire  [16:0] fix_mem_addr;            // translated address of the fixed-window variant
  // bookkeeping
  int          n_errors = 0;
  int          checked  = 0;
  logic [31:0] rd;
  int          b, np;

  // 100 ns clock
  always #50 sys_clk = ~sys_clk;

  csbm_top #(.FOUR_BANKS(1'b1)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
    .cpu_gnt(cpu_gnt), .dma_req(dma_req), .dma_addr(dma_addr), .dma_gnt(dma_gnt),
    .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_to_ram(mem_to_ram), .mem_src(mem_src),
    .cache_bypass(cache_bypass), .cache_invalidate(cache_invalidate));
  // fixed-window variant sees the same bus and the same requests
  csbm_top #(.FOUR_BANKS(1'b0)) dut_fixed (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(1'b1), .hwdata(hwdata), .hrdata(),
    .hreadyout(), .hresp(), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_gnt(),
    .dma_req(dma_req), .dma_addr(dma_addr), .dma_gnt(), .mem_valid(),
    .mem_addr(fix_mem_addr), .mem_to_ram(), .mem_src(), .cache_bypass(),
    .cache_invalidate());
  // processor and dma requestors
  csbm_req_model u_cpu (.sys_clk(sys_clk), .gnt(cpu_gnt), .req(cpu_req), .addr(cpu_addr));
  csbm_req_model u_dma (.sys_clk(sys_clk), .gnt(dma_gnt), .req(dma_req), .addr(dma_addr));

  // verdict and end of run
  task automatic test_done;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // wait for hready high at a rising edge, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_errors++;
        test_done;
      end
      @(posedge sys_clk);
    end
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= csbm_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy;
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  // read a register and compare the whole word
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    ahb(1'b0, a, 8'h00);
    `CHK(nm, exp, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask

  // one access through a requestor, then the translated access is judged
  task automatic fetch(input bit dma, input logic [15:0] a, input logic [16:0] ea,
                       input logic er);
    bit ok;
    if (dma) begin
      u_dma.fetch(a, ok);
    end else begin
      u_cpu.fetch(a, ok);
    end
    if (!ok) begin
      n_errors++;
      test_done;
    end
    #1;
    `CHK("mem_valid", 1'b1, mem_valid)
    `CHK("mem_addr", ea, mem_addr)
    `CHK("mem_to_ram", er, mem_to_ram)
    `CHK("mem_src", dma, mem_src)
  endtask

  // count invalidate pulses over a few cycles and check the bypass level
  task automatic cache_chk(input int exp_pulses, input logic exp_byp);
    np = 0;
    repeat (5) begin
      #1;
      if (cache_invalidate === 1'b1) np++;
      @(posedge sys_clk);
    end
    `CHK("cache_invalidate", exp_pulses, np)
    `CHK("cache_bypass", exp_byp, cache_bypass)
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_chk(csbm_pkg::ADDR_ARB_CTRL, 32'h11, "arb_ctrl reset");
    rd_chk(csbm_pkg::ADDR_BANK_SEL, 32'h01, "bank_sel reset");
    // every bank through the alias, junk in the unused bits
    for (b = 0; b < 4; b++) begin
      ahb(1'b1, csbm_pkg::ADDR_BANK_SEL, {6'h3F, 2'(b)});
      rd_chk(csbm_pkg::ADDR_BANK_SEL, {30'h0, 2'(b)}, "bank_sel");
      rd_chk(csbm_pkg::ADDR_ARB_CTRL, {26'h0, 2'(b), 4'h1}, "arb_ctrl alias");
      fetch(1'b0, 16'h8123, {2'(b), 15'h0123}, 1'b0);
      `CHK("fixed window", {2'h1, 15'h0123}, fix_mem_addr)
      fetch(1'b1, 16'h0456, 17'h00456, 1'b0);
    end
    // write through the control register, unused bits set
    ahb(1'b1, csbm_pkg::ADDR_ARB_CTRL, 8'h8D);
    rd_chk(csbm_pkg::ADDR_ARB_CTRL, 32'h01, "arb_ctrl unused");
    rd_chk(csbm_pkg::ADDR_BANK_SEL, 32'h00, "bank_sel alias");
    fetch(1'b0, 16'hE010, 17'h06010, 1'b0);
    // unified mapping is enabled before any ram code is fetched
    ahb(1'b1, csbm_pkg::ADDR_ARB_CTRL, 8'h41);
    fetch(1'b0, 16'hE010, 17'h00010, 1'b1);
    // served by dma so that dma loses the next tie and is served one cycle later
    fetch(1'b1, 16'h9000, 17'h01000, 1'b0);
    // both requestors at once
    fork
      fetch(1'b0, 16'h0010, 17'h00010, 1'b0);
      fetch(1'b1, 16'hE020, 17'h00020, 1'b1);
    join
    // cache off then on again
    ahb(1'b1, csbm_pkg::ADDR_ARB_CTRL, 8'h43);
    cache_chk(1, 1'b1);
    ahb(1'b1, csbm_pkg::ADDR_ARB_CTRL, 8'h41);
    cache_chk(0, 1'b0);
    test_done;
  end
endmodule // code_space_bank_mapper_tb

// *** csbm_pkg.sv ***
package csbm_pkg;
  // printed register indices, byte address is four times the index
  localparam logic [7:0]  IDX_BANK_SEL  = 8'h9F;  // flash_bank_select
  localparam logic [7:0]  IDX_ARB_CTRL  = 8'hC7;  // memory_arbiter_control
  localparam logic [11:0] ADDR_BANK_SEL = {2'h0, IDX_BANK_SEL, 2'h0};
  localparam logic [11:0] ADDR_ARB_CTRL = {2'h0, IDX_ARB_CTRL, 2'h0};
  // memory_arbiter_control fields
  localparam int          ARB_UNIF_BIT  = 6;      // unified_map_enable
  localparam int          ARB_MAP_LSB   = 4;      // bank select copy, bits 5:4
  localparam int          ARB_CDIS_BIT  = 1;      // instruction_cache_off
  localparam int          ARB_RSV_BIT   = 0;      // reserved, software keeps it 1
  // flash_bank_select fields
  localparam int          BANK_MAP_LSB  = 0;      // bank_select_alias, bits 1:0
  // reset values
  localparam logic [1:0]  MAP_RST       = 2'h1;
  localparam logic        UNIF_RST      = 1'b0;
  localparam logic        CDIS_RST      = 1'b0;
  localparam logic        RSV_RST       = 1'b1;
  // code space layout
  localparam logic [15:0] RAM_BASE      = 16'hE000; // unified view of on-chip ram
  // ahb encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
  // arbiter requestor
  typedef enum logic {
    CSBM_SRC_CPU = 1'b0,
    CSBM_SRC_DMA = 1'b1
  } csbm_src_t;
endpackage

// *** csbm_req_model.sv ***
// requestor at the far side of the arbiter: processor fetch or dma access
module csbm_req_model (
  // clock
  input  wire logic        sys_clk,
  // grant from the arbiter
  input  wire logic        gnt,
  // request toward the arbiter
  output logic             req,
  output logic [15:0]      addr
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle requestor raises no request
  initial begin
    req  = 1'b0;
    addr = 16'h0000;
  end

  // one access: request and address hold until a grant is sampled
  task automatic fetch(input logic [15:0] a, output bit ok);
    int n;
    @(posedge sys_clk);
    req  <= 1'b1;
    addr <= a;
    n    = 0;
    ok   = 1'b0;
    while (!ok && n < 20) begin
      @(posedge sys_clk);
      ok = (gnt === 1'b1);
      n++;
    end
    req  <= 1'b0;
    // a released address must not keep showing the fetched value
    addr <= ~a;
  endtask
endmodule // csbm_req_model

// *** csbm_top.sv ***
// What this block does
// - unified bit maps on-chip ram into code from E000
// - bank field picks upper window flash bank
// - bank n maps to physical n times 32K
// - bank field resets to one
// - both bank fields share one storage
// - banking present only in four-bank variant
// - cache-off bit invalidates and bypasses cache
// - unused bits read zero, ignore writes
// - arbiter serves cpu and dma requests
module csbm_top #(
  parameter bit FOUR_BANKS = 1'b1          // variant with four 32 KB banks
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // cpu code fetch request
  input  wire logic        cpu_req,
  input  wire logic [15:0] cpu_addr,
  output logic             cpu_gnt,
  // dma code space request
  input  wire logic        dma_req,
  input  wire logic [15:0] dma_addr,
  output logic             dma_gnt,
  // translated access toward memories
  output logic             mem_valid,
  output logic [16:0]      mem_addr,
  output logic             mem_to_ram,
  output logic             mem_src,
  // instruction cache control
  output logic             cache_bypass,
  output logic             cache_invalidate
);

  logic        rst_meta_ff;              // reset release stage one
  logic        rst_n;                    // synchronised reset
  logic [1:0]  map_ff;                   // shared bank select storage
  logic        unif_ff;                  // unified mapping enable
  logic        cdis_ff;                  // cache disable
  logic        rsv_ff;                   // reserved bit zero
  logic        inv_ff;                   // invalidate pulse
  logic        wr_pend_ff;               // write data phase pending
  logic [11:0] wr_addr_ff;               // address of pending write
  logic [31:0] rdata_ff;                 // read data register
  logic        last_dma_ff;              // dma served last
  logic        mem_valid_ff;
  logic [16:0] mem_addr_ff;
  logic        mem_ram_ff;
  logic        mem_src_ff;
  logic [1:0]  nxt_map;
  logic        nxt_unif;
  logic        nxt_cdis;
  logic        nxt_rsv;
  logic        addr_ok;                  // valid address phase
  logic [1:0]  eff_bank;                 // bank seen by the window
  logic [15:0] sel_addr;                 // granted code address
  logic [17:0] xlat;                     // {to_ram, physical}

  // arbiter control register image, unused bits zero
  function automatic logic [7:0] arb_img(logic u, logic [1:0] m, logic c, logic r);
    logic [7:0] v;
    v = 8'h00;
    v[csbm_pkg::ARB_UNIF_BIT] = u;
    v[csbm_pkg::ARB_MAP_LSB +: 2] = m;
    v[csbm_pkg::ARB_CDIS_BIT] = c;
    v[csbm_pkg::ARB_RSV_BIT] = r;
    return v;
  endfunction

  // bank map register image, bits 7:2 zero
  function automatic logic [7:0] bank_img(logic [1:0] m);
    logic [7:0] v;
    v = 8'h00;
    v[csbm_pkg::BANK_MAP_LSB +: 2] = m;
    return v;
  endfunction

  // code address to physical address
  function automatic logic [17:0] map_code(logic [15:0] a, logic [1:0] b, logic u);
    logic [17:0] r;
    r = {1'b0, 1'b0, a};
    if (u && a >= csbm_pkg::RAM_BASE) begin
      r = {1'b1, 1'b0, a - csbm_pkg::RAM_BASE};
    end else if (a[15]) begin
      r = {1'b0, b, a[14:0]};
    end
    return r;
  endfunction

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  // ahb address phase qualifier
  assign addr_ok = hsel && hready && (htrans == csbm_pkg::HTRANS_NONSEQ ||
                                      htrans == csbm_pkg::HTRANS_SEQ);

  // write data phase tracking
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
    end else begin
      wr_pend_ff <= addr_ok && hwrite;
      wr_addr_ff <= haddr;
    end
  end

  // next register values from the write data phase
  always_comb begin
    nxt_map  = map_ff;
    nxt_unif = unif_ff;
    nxt_cdis = cdis_ff;
    nxt_rsv  = rsv_ff;
    if (wr_pend_ff && wr_addr_ff == csbm_pkg::ADDR_ARB_CTRL) begin
      nxt_map  = hwdata[csbm_pkg::ARB_MAP_LSB +: 2];
      nxt_unif = hwdata[csbm_pkg::ARB_UNIF_BIT];
      nxt_cdis = hwdata[csbm_pkg::ARB_CDIS_BIT];
      nxt_rsv  = hwdata[csbm_pkg::ARB_RSV_BIT];
    end else if (wr_pend_ff && wr_addr_ff == csbm_pkg::ADDR_BANK_SEL) begin
      nxt_map  = hwdata[csbm_pkg::BANK_MAP_LSB +: 2];
    end
  end

  // control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      map_ff  <= csbm_pkg::MAP_RST;
      unif_ff <= csbm_pkg::UNIF_RST;
      cdis_ff <= csbm_pkg::CDIS_RST;
      rsv_ff  <= csbm_pkg::RSV_RST;
    end else begin
      map_ff  <= nxt_map;
      unif_ff <= nxt_unif;
      cdis_ff <= nxt_cdis;
      rsv_ff  <= nxt_rsv;
    end
  end

  // read data captured from next values so a write just before is seen
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      if (haddr == csbm_pkg::ADDR_ARB_CTRL) begin
        rdata_ff <= {24'h000000, arb_img(nxt_unif, nxt_map, nxt_cdis, nxt_rsv)};
      end else if (haddr == csbm_pkg::ADDR_BANK_SEL) begin
        rdata_ff <= {24'h000000, bank_img(nxt_map)};
      end else begin
        rdata_ff <= 32'h00000000;                      // unmapped reads zero
      end
    end
  end

  // bus answers: no wait states, always okay
  assign hrdata    = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // cache control, invalidate pulses when the cache is turned off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      inv_ff <= 1'b0;
    end else begin
      inv_ff <= nxt_cdis && !cdis_ff;
    end
  end
  assign cache_bypass     = cdis_ff;
  assign cache_invalidate = inv_ff;

  // smaller variants keep a fixed window on the second bank
  assign eff_bank = FOUR_BANKS ? map_ff : csbm_pkg::MAP_RST;

  // round robin between cpu and dma
  always_comb begin
    cpu_gnt = 1'b0;
    dma_gnt = 1'b0;
    if (cpu_req && dma_req) begin
      cpu_gnt = last_dma_ff;
      dma_gnt = !last_dma_ff;
    end else begin
      cpu_gnt = cpu_req;
      dma_gnt = dma_req;
    end
  end
  assign sel_addr = dma_gnt ? dma_addr : cpu_addr;
  assign xlat     = map_code(sel_addr, eff_bank, unif_ff);

  // fairness state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_dma_ff <= 1'b0;
    end else if (cpu_gnt || dma_gnt) begin
      last_dma_ff <= dma_gnt;
    end
  end

  // registered translated access
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_valid_ff <= 1'b0;
      mem_addr_ff  <= 17'h00000;
      mem_ram_ff   <= 1'b0;
      mem_src_ff   <= csbm_pkg::CSBM_SRC_CPU;
    end else begin
      mem_valid_ff <= cpu_gnt || dma_gnt;
      mem_addr_ff  <= xlat[16:0];
      mem_ram_ff   <= xlat[17];
      mem_src_ff   <= dma_gnt;
    end
  end
  assign mem_valid  = mem_valid_ff;
  assign mem_addr   = mem_addr_ff;
  assign mem_to_ram = mem_ram_ff;
  assign mem_src    = mem_src_ff;

  // assertions
  sequence cdis_rise_s;
    $rose(cdis_ff);
  endsequence
  sequence inv_pulse_s;
    inv_ff ##1 !inv_ff;
  endsequence

  flash_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((cpu_gnt || dma_gnt) && !unif_ff) |=> (mem_valid && !mem_to_ram))
    else $error("ram routed while unified mapping off");
  window_bank_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((cpu_gnt || dma_gnt) && sel_addr[15] && !(unif_ff && sel_addr >= 16'hE000))
    |=> (mem_addr[16:15] == $past(eff_bank) && mem_addr[14:0] == $past(sel_addr[14:0])))
    else $error("upper window not on selected bank");
  low_half_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((cpu_gnt || dma_gnt) && !sel_addr[15]) |=> (mem_addr == {1'b0, $past(sel_addr)}))
    else $error("lower half not on bank zero");
  bank_reset_a: assert property (@(posedge sys_clk)
    (rst_n && !$past(rst_n)) |-> (map_ff == 2'h1 && !unif_ff && !cdis_ff && rsv_ff))
    else $error("wrong reset value");
  alias_shared_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_pend_ff && wr_addr_ff == csbm_pkg::ADDR_BANK_SEL) |=>
    (map_ff == $past(hwdata[csbm_pkg::BANK_MAP_LSB +: 2])))
    else $error("bank alias not shared");
  variant_fixed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !FOUR_BANKS |-> eff_bank == 2'h1)
    else $error("banking active in small variant");
  cache_inval_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cdis_rise_s |-> inv_pulse_s)
    else $error("cache not invalidated");
  cache_bypass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_pend_ff && wr_addr_ff == csbm_pkg::ADDR_ARB_CTRL) |=>
    (cache_bypass == $past(hwdata[1])))
    else $error("cache bypass not following write");
  unused_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (addr_ok && !hwrite) |=> (hrdata[31:8] == 24'h000000 && hrdata[7] == 1'b0 &&
    ($past(haddr) != csbm_pkg::ADDR_ARB_CTRL || hrdata[3:2] == 2'h0) &&
    ($past(haddr) != csbm_pkg::ADDR_BANK_SEL || hrdata[7:2] == 6'h00)))
    else $error("unused bits not zero");
  dma_served_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dma_req && !dma_gnt) ##1 dma_req |-> (dma_gnt && !cpu_gnt))
    else $error("dma starved");

endmodule // csbm_top
